// [core/aom_core.sv]
// Angle output mapping core: bridge sampling, angle, range mapping and storage.
// Assumes an on-chip converter and storage macro on mclk, and a link decoder on mclk.
//
// Behaviour
// - Sample both bridge channels alternately through one converter.
// - Remove channel offsets, then compute the angle by iterative vector rotation.
// - Subtract programmed zero angle and scale by programmed range before output.
// - Angle wraps every half turn relative to the zero angle.
// - Map angle linearly to the output code; control bit selects rising or falling.
// - Rising: between maximum and switch angle, output the upper clamp level.
// - Rising: from switch angle up to zero plus half turn, output lower clamp.
// - Falling slope swaps upper and lower clamp levels in those regions.
// - Valid output lies inside the clamp band; outer band is reserved for errors.
// - Zero, both clamps and range are kept in non-volatile storage.
// - Two 16-bit user words can be written and read back.
// - Storage is reached only through the single line programming link.
// - Once the lock bit is set, every later write is refused for good.
// - After reset, stored words are copied into shadow registers.
// - Words carry check bits; single errors corrected, double errors force diagnosis.
`timescale 1ns/1ps
module aom_core (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [11:0] adc_data,
   input wire logic adc_valid,
   output logic adc_start,
   output logic chan_sel,
   input wire logic [11:0] chan_offset_x,
   input wire logic [11:0] chan_offset_y,
   input wire logic magnet_weak,
   input wire logic bridge_open,
   input wire logic supply_bad,
   output logic nvm_rd,
   output logic nvm_wr,
   output logic [3:0] nvm_addr,
   output logic [21:0] nvm_wdata,
   input wire logic [21:0] nvm_rdata,
   input wire logic link_wr,
   input wire logic link_rd,
   input wire logic [3:0] link_addr,
   input wire logic [15:0] link_wdata,
   output logic [15:0] link_rdata,
   output logic link_rvalid,
   output logic link_refused,
   output logic [11:0] dac_code,
   output logic diag_active,
   output logic boot_done,
   output logic locked
);
   aom_pkg::aom_meas_type meas_q;
   aom_pkg::aom_boot_type boot_q;
   logic [15:0] shadow_q [0:8];
   logic [3:0] boot_idx_q;
   logic dbl_err_q;
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic signed [12:0] x_q;
   logic signed [12:0] y_now;
   logic cordic_start;
   logic cordic_done;
   logic [15:0] angle;
   logic [21:0] enc_code;
   logic [15:0] dec_data;
   logic dec_double;
   logic addr_ok;
   logic wr_ok;
   logic rd_ok;
   logic map_fire;
   logic diag;
   logic falling;
   logic [15:0] rel;
   logic [31:0] prod;
   logic [11:0] lower_c;
   logic [11:0] upper_c;
   logic [11:0] band;
   logic [11:0] span;
   logic [11:0] mapped;
   logic [11:0] diag_code;

   ////////////////////////////////////////////////////////////////////////////////
   // Analog fault flags are asynchronous; each goes through two flops first.
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         pin_s1_q <= {supply_bad, bridge_open, magnet_weak};
         pin_s2_q <= pin_s1_q;
      end
   end

   aom_word_guard u_guard (
      .enc_data(link_wdata),
      .enc_code(enc_code),
      .dec_code(nvm_rdata),
      .dec_data(dec_data),
      .dec_single(),
      .dec_double(dec_double)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Boot copy of storage into shadows, one word every three cycles.
   always_ff @(posedge mclk) begin
      if (rst) begin
         boot_q <= aom_pkg::B_ISSUE;
         boot_idx_q <= 4'h0;
         dbl_err_q <= 1'b0;
      end else begin
         case (boot_q)
            aom_pkg::B_ISSUE: begin
               boot_q <= aom_pkg::B_WAIT;
            end
            aom_pkg::B_WAIT: begin
               boot_q <= aom_pkg::B_TAKE;
            end
            aom_pkg::B_TAKE: begin
               if (dec_double) begin
                  dbl_err_q <= 1'b1;
               end
               if (boot_idx_q == aom_pkg::BOOT_LAST) begin
                  boot_q <= aom_pkg::B_DONE;
               end else begin
                  boot_idx_q <= boot_idx_q + 4'h1;
                  boot_q <= aom_pkg::B_ISSUE;
               end
            end
            default: begin
               boot_q <= aom_pkg::B_DONE;
            end
         endcase
      end
   end

   assign boot_done = (boot_q == aom_pkg::B_DONE);
   assign locked = shadow_q[aom_pkg::IDX_CTRL][aom_pkg::CTRL_LOCK];
   assign addr_ok = (link_addr <= aom_pkg::BOOT_LAST);
   assign wr_ok = link_wr && boot_done && addr_ok && !locked;
   assign rd_ok = link_rd && boot_done && addr_ok;
   assign link_refused = (link_wr && !wr_ok) || (link_rd && !rd_ok);

   ////////////////////////////////////////////////////////////////////////////////
   // Shadows hold the working configuration; a link write updates both copies.
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < 9; i++) begin
            shadow_q[i] <= aom_pkg::SHADOW_RESET;
         end
      end else if (boot_q == aom_pkg::B_TAKE) begin
         shadow_q[boot_idx_q] <= dec_data;
      end else if (wr_ok) begin
         shadow_q[link_addr] <= link_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         nvm_rd <= 1'b0;
         nvm_wr <= 1'b0;
         nvm_addr <= 4'h0;
         nvm_wdata <= 22'h000000;
      end else begin
         nvm_rd <= (boot_q == aom_pkg::B_ISSUE);
         nvm_wr <= wr_ok;
         if (boot_q == aom_pkg::B_ISSUE) begin
            nvm_addr <= boot_idx_q;
         end else if (wr_ok) begin
            nvm_addr <= link_addr;
            nvm_wdata <= enc_code;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         link_rvalid <= 1'b0;
         link_rdata <= 16'h0000;
      end else begin
         link_rvalid <= rd_ok;
         if (rd_ok) begin
            link_rdata <= shadow_q[link_addr];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Measurement loop: x sample, y sample, rotation, mapping, and again.
   assign adc_start = (meas_q == aom_pkg::M_CONV_X) || (meas_q == aom_pkg::M_CONV_Y);
   assign y_now = $signed({1'b0, adc_data}) - $signed({1'b0, chan_offset_y});
   assign cordic_start = (meas_q == aom_pkg::M_WAIT_Y) && adc_valid;
   assign map_fire = (meas_q == aom_pkg::M_MAP);

   always_ff @(posedge mclk) begin
      if (rst) begin
         meas_q <= aom_pkg::M_IDLE;
         chan_sel <= 1'b0;
         x_q <= 13'sh0000;
      end else begin
         case (meas_q)
            aom_pkg::M_IDLE: begin
               if (boot_done) begin
                  meas_q <= aom_pkg::M_CONV_X;
               end
            end
            aom_pkg::M_CONV_X: begin
               meas_q <= aom_pkg::M_WAIT_X;
            end
            aom_pkg::M_WAIT_X: begin
               if (adc_valid) begin
                  x_q <= $signed({1'b0, adc_data}) - $signed({1'b0, chan_offset_x});
                  chan_sel <= 1'b1;
                  meas_q <= aom_pkg::M_CONV_Y;
               end
            end
            aom_pkg::M_CONV_Y: begin
               meas_q <= aom_pkg::M_WAIT_Y;
            end
            aom_pkg::M_WAIT_Y: begin
               if (adc_valid) begin
                  chan_sel <= 1'b0;
                  meas_q <= aom_pkg::M_WAIT_C;
               end
            end
            aom_pkg::M_WAIT_C: begin
               if (cordic_done) begin
                  meas_q <= aom_pkg::M_MAP;
               end
            end
            default: begin
               meas_q <= aom_pkg::M_CONV_X;
            end
         endcase
      end
   end

   aom_cordic #(
      .IN_W(13),
      .ITER(aom_pkg::CORDIC_ITER)
   ) u_cordic (
      .mclk(mclk),
      .rst(rst),
      .start(cordic_start),
      .x_in(x_q),
      .y_in(y_now),
      .busy(),
      .done(cordic_done),
      .angle(angle)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // The rotator sees doubled bridge angles, so a full 16-bit wrap is half a turn.
   assign falling = shadow_q[aom_pkg::IDX_CTRL][aom_pkg::CTRL_FALLING];
   assign rel = angle - shadow_q[aom_pkg::IDX_ZERO];
   assign prod = 32'(rel) * 32'(shadow_q[aom_pkg::IDX_GAIN]);

   // Clamp levels are pulled into the valid band so a bad setting cannot fake an error.
   always_comb begin
      lower_c = shadow_q[aom_pkg::IDX_LOWER][11:0];
      upper_c = shadow_q[aom_pkg::IDX_UPPER][11:0];
      if (lower_c < aom_pkg::VALID_MIN) lower_c = aom_pkg::VALID_MIN;
      if (lower_c > aom_pkg::VALID_MAX) lower_c = aom_pkg::VALID_MAX;
      if (upper_c < aom_pkg::VALID_MIN) upper_c = aom_pkg::VALID_MIN;
      if (upper_c > aom_pkg::VALID_MAX) upper_c = aom_pkg::VALID_MAX;
      if (upper_c < lower_c) upper_c = lower_c;
   end

   assign band = upper_c - lower_c;

   always_comb begin
      if (prod[31:28] != 4'h0 || prod[27:16] > band) begin
         span = band;
      end else begin
         span = prod[27:16];
      end
      if (rel <= shadow_q[aom_pkg::IDX_MAX]) begin
         mapped = falling ? upper_c - span : lower_c + span;
      end else if (rel < shadow_q[aom_pkg::IDX_SWITCH]) begin
         mapped = falling ? lower_c : upper_c;
      end else begin
         mapped = falling ? upper_c : lower_c;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Before boot ends or with a bad supply only the low code is trustworthy.
   assign diag = !boot_done || dbl_err_q || pin_s2_q[2] || pin_s2_q[1]
                 || (pin_s2_q[0] && shadow_q[aom_pkg::IDX_CTRL][aom_pkg::CTRL_MAG_EN]);
   assign diag_code = (!boot_done || pin_s2_q[2] || !shadow_q[aom_pkg::IDX_CTRL][aom_pkg::CTRL_DIAG_HIGH])
                      ? aom_pkg::DIAG_LOW_CODE : aom_pkg::DIAG_HIGH_CODE;

   always_ff @(posedge mclk) begin
      if (rst) begin
         dac_code <= aom_pkg::DIAG_LOW_CODE;
         diag_active <= 1'b1;
      end else begin
         diag_active <= diag;
         if (diag) begin
            dac_code <= diag_code;
         end else if (map_fire) begin
            dac_code <= mapped;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_CHAN_X: assert property (@(posedge mclk) disable iff (rst)
      (meas_q == aom_pkg::M_WAIT_X) |-> !chan_sel) else $error("x sample taken on wrong channel");
   AST_CHAN_Y: assert property (@(posedge mclk) disable iff (rst)
      (meas_q == aom_pkg::M_WAIT_X && adc_valid) |=> chan_sel ##1 (chan_sel && meas_q == aom_pkg::M_WAIT_Y))
      else $error("y sample does not follow x sample");
   AST_ROT_SEQ: assert property (@(posedge mclk) disable iff (rst)
      (meas_q == aom_pkg::M_WAIT_C && cordic_done) |=> map_fire ##1 (meas_q == aom_pkg::M_CONV_X))
      else $error("mapping does not follow rotation");
   AST_ZERO_POINT: assert property (@(posedge mclk) disable iff (rst)
      (map_fire && !diag && rel == 16'h0000 && !falling) |=> (dac_code == $past(lower_c)))
      else $error("zero angle does not give lower clamp");
   AST_FALL_ZERO: assert property (@(posedge mclk) disable iff (rst)
      (map_fire && !diag && rel == 16'h0000 && falling) |=> (dac_code == $past(upper_c)))
      else $error("falling slope zero angle does not give upper clamp");
   AST_OVER_RANGE: assert property (@(posedge mclk) disable iff (rst)
      (map_fire && !diag && !falling && rel > shadow_q[aom_pkg::IDX_MAX] && rel < shadow_q[aom_pkg::IDX_SWITCH])
      |=> (dac_code == $past(upper_c))) else $error("over range does not give upper clamp");
   AST_PAST_SWITCH: assert property (@(posedge mclk) disable iff (rst)
      (map_fire && !diag && !falling && rel > shadow_q[aom_pkg::IDX_MAX] && rel >= shadow_q[aom_pkg::IDX_SWITCH])
      |=> (dac_code == $past(lower_c))) else $error("past switch angle does not give lower clamp");
   AST_FALL_SWAP: assert property (@(posedge mclk) disable iff (rst)
      (map_fire && !diag && falling && rel > shadow_q[aom_pkg::IDX_MAX] && rel < shadow_q[aom_pkg::IDX_SWITCH])
      |=> (dac_code == $past(lower_c))) else $error("falling slope clamps not swapped");
   AST_VALID_BAND: assert property (@(posedge mclk) disable iff (rst)
      (map_fire && !diag) |=> (dac_code >= aom_pkg::VALID_MIN && dac_code <= aom_pkg::VALID_MAX))
      else $error("angle code outside valid band");
   AST_DIAG_BAND: assert property (@(posedge mclk) disable iff (rst)
      diag |=> (diag_active && (dac_code < aom_pkg::VALID_MIN || dac_code > aom_pkg::VALID_MAX)))
      else $error("diagnostic condition without diagnostic code");
   AST_LOCK_REFUSE: assert property (@(posedge mclk) disable iff (rst)
      (locked && link_wr) |-> link_refused ##1 !nvm_wr) else $error("write accepted after lock");
   AST_LOCK_STAYS: assert property (@(posedge mclk) disable iff (rst)
      locked |=> locked) else $error("lock bit cleared");
   AST_DOUBLE_ERR: assert property (@(posedge mclk) disable iff (rst)
      (boot_q == aom_pkg::B_TAKE && dec_double) |-> ##2 diag_active ##1 diag_active)
      else $error("double bit error did not force diagnosis");
   AST_BOOT_COPY: assert property (@(posedge mclk) disable iff (rst)
      $rose(boot_done) |-> ($past(boot_idx_q) == aom_pkg::BOOT_LAST && $past(boot_q) == aom_pkg::B_TAKE))
      else $error("boot ended before last word copied");
   AST_USER_READ: assert property (@(posedge mclk) disable iff (rst)
      (rd_ok && link_addr == aom_pkg::IDX_USER0) |=> (link_rvalid && link_rdata == $past(shadow_q[aom_pkg::IDX_USER0])))
      else $error("user word read back wrong");
endmodule

// [core/aom_pkg.sv]
// Shared constants and types of the angle output mapping core.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package aom_pkg;
   localparam int ADC_W = 12;
   localparam int DAC_W = 12;
   localparam int WORD_W = 16;
   localparam int CODE_W = 22;
   localparam int ADDR_W = 4;
   localparam int CORDIC_ITER = 14;

   // Configuration word indices in non-volatile storage.
   localparam logic [3:0] IDX_ZERO = 4'h0;
   localparam logic [3:0] IDX_MAX = 4'h1;
   localparam logic [3:0] IDX_SWITCH = 4'h2;
   localparam logic [3:0] IDX_UPPER = 4'h3;
   localparam logic [3:0] IDX_LOWER = 4'h4;
   localparam logic [3:0] IDX_GAIN = 4'h5;
   localparam logic [3:0] IDX_CTRL = 4'h6;
   localparam logic [3:0] IDX_USER0 = 4'h7;
   localparam logic [3:0] IDX_USER1 = 4'h8;
   localparam logic [3:0] BOOT_LAST = 4'h8;

   // Control word bit positions.
   localparam int CTRL_FALLING = 0;
   localparam int CTRL_DIAG_HIGH = 1;
   localparam int CTRL_MAG_EN = 2;
   localparam int CTRL_LOCK = 15;

   localparam logic [15:0] SHADOW_RESET = 16'h0000;
   localparam logic [15:0] HALF_TURN = 16'h8000;

   // Output codes; the valid band is 4 to 96 percent of full scale.
   localparam logic [11:0] DIAG_LOW_CODE = 12'h020;
   localparam logic [11:0] DIAG_HIGH_CODE = 12'hfe0;
   localparam logic [11:0] VALID_MIN = 12'h0a4;
   localparam logic [11:0] VALID_MAX = 12'hf5c;

   typedef enum {M_IDLE, M_CONV_X, M_WAIT_X, M_CONV_Y, M_WAIT_Y, M_WAIT_C, M_MAP} aom_meas_type;
   typedef enum {B_ISSUE, B_WAIT, B_TAKE, B_DONE} aom_boot_type;
endpackage

// [core/aom_cordic.sv]
// Iterative vectoring rotator: turns an x/y pair into a 16-bit angle.
// Assumes start is a one-cycle pulse and is not repeated while busy.
`timescale 1ns/1ps
module aom_cordic #(
   parameter int IN_W = 13,
   parameter int ITER = aom_pkg::CORDIC_ITER
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic signed [IN_W-1:0] x_in,
   input wire logic signed [IN_W-1:0] y_in,
   output logic busy,
   output logic done,
   output logic [15:0] angle
);
   logic signed [15:0] x_q;
   logic signed [15:0] y_q;
   logic [15:0] z_q;
   logic [3:0] iter_q;
   logic signed [15:0] sx;
   logic signed [15:0] sy;

   function automatic logic [15:0] atan_step(input logic [3:0] i);
      case (i)
         4'h0: atan_step = 16'h2000;
         4'h1: atan_step = 16'h12e4;
         4'h2: atan_step = 16'h09fb;
         4'h3: atan_step = 16'h0511;
         4'h4: atan_step = 16'h028b;
         4'h5: atan_step = 16'h0146;
         4'h6: atan_step = 16'h00a3;
         4'h7: atan_step = 16'h0051;
         4'h8: atan_step = 16'h0029;
         4'h9: atan_step = 16'h0014;
         4'ha: atan_step = 16'h000a;
         4'hb: atan_step = 16'h0005;
         4'hc: atan_step = 16'h0003;
         default: atan_step = 16'h0001;
      endcase
   endfunction

   assign sx = x_q >>> iter_q;
   assign sy = y_q >>> iter_q;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (rst) begin
         x_q <= 16'sh0000;
         y_q <= 16'sh0000;
         z_q <= 16'h0000;
         iter_q <= 4'h0;
         busy <= 1'b0;
         done <= 1'b0;
         angle <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (start) begin
            // A left-half vector is turned by half a circle first so the steps converge.
            if (x_in < 0) begin
               x_q <= -16'(x_in);
               y_q <= -16'(y_in);
               z_q <= aom_pkg::HALF_TURN;
            end else begin
               x_q <= 16'(x_in);
               y_q <= 16'(y_in);
               z_q <= 16'h0000;
            end
            iter_q <= 4'h0;
            busy <= 1'b1;
         end else if (busy) begin
            if (!y_q[15]) begin
               x_q <= x_q + sy;
               y_q <= y_q - sx;
               z_q <= z_q + atan_step(iter_q);
            end else begin
               x_q <= x_q - sy;
               y_q <= y_q + sx;
               z_q <= z_q - atan_step(iter_q);
            end
            iter_q <= iter_q + 4'h1;
            if (iter_q == 4'(ITER - 1)) begin
               busy <= 1'b0;
               done <= 1'b1;
               angle <= (!y_q[15]) ? z_q + atan_step(iter_q) : z_q - atan_step(iter_q);
            end
         end
      end
   end
endmodule

// [core/aom_word_guard.sv]
// Encoder and decoder for 16-bit words kept as 22-bit code words.
// Purely combinational; code bit 0 is overall parity, bits 1..21 a Hamming code.
`timescale 1ns/1ps
module aom_word_guard (
   input wire logic [15:0] enc_data,
   output logic [21:0] enc_code,
   input wire logic [21:0] dec_code,
   output logic [15:0] dec_data,
   output logic dec_single,
   output logic dec_double
);
   always_comb begin
      int j;
      enc_code = 22'h000000;
      j = 0;
      for (int p = 1; p < 22; p++) begin
         if ((p & (p - 1)) != 0) begin
            enc_code[p] = enc_data[j];
            j++;
         end
      end
      for (int k = 0; k < 5; k++) begin
         for (int p = 1; p < 22; p++) begin
            if (((p >> k) & 1) == 1 && p != (1 << k)) begin
               enc_code[1 << k] = enc_code[1 << k] ^ enc_code[p];
            end
         end
      end
      enc_code[0] = ^enc_code[21:1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [4:0] syn;
      logic par;
      logic [21:0] fixed;
      int j;
      syn = 5'h00;
      par = ^dec_code;
      fixed = dec_code;
      dec_single = 1'b0;
      dec_double = 1'b0;
      dec_data = 16'h0000;
      j = 0;
      for (int p = 1; p < 22; p++) begin
         for (int k = 0; k < 5; k++) begin
            if (((p >> k) & 1) == 1) begin
               syn[k] = syn[k] ^ dec_code[p];
            end
         end
      end
      // An even overall parity with a nonzero syndrome means two flipped bits.
      if (syn != 5'h00 && par) begin
         if (syn < 5'h16) begin
            fixed[syn] = ~fixed[syn];
            dec_single = 1'b1;
         end else begin
            dec_double = 1'b1;
         end
      end else if (syn != 5'h00) begin
         dec_double = 1'b1;
      end else if (par) begin
         dec_single = 1'b1;
      end
      for (int p = 1; p < 22; p++) begin
         if ((p & (p - 1)) != 0) begin
            dec_data[j] = fixed[p];
            j++;
         end
      end
   end
endmodule

// [verification/aom_far_side.sv]
// Far side of the core: bridge converter and word storage, behavioural.
// Assumes the core's one clock; converter latency picked by slow.
`timescale 1ns/1ps
module aom_far_side (
   input wire logic mclk,
   input wire logic adc_start,
   input wire logic chan_sel,
   input wire logic [11:0] x_raw,
   input wire logic [11:0] y_raw,
   input wire logic slow,
   output logic [11:0] adc_data,
   output logic adc_valid,
   input wire logic nvm_rd,
   input wire logic nvm_wr,
   input wire logic [3:0] nvm_addr,
   input wire logic [21:0] nvm_wdata,
   output logic [21:0] nvm_rdata
);
   logic [21:0] mem [0:15];
   int wait_q = -1;
   logic sel_q = 1'b0;
   initial begin
      foreach (mem[i]) begin
         mem[i] = 22'h000000;
      end
      adc_data = 12'h000;
      adc_valid = 1'b0;
      nvm_rdata = 22'h000000;
   end
   ////////////////////////////////////////////////////////////
   // Buses toggle when idle, so a stale sample is never mistaken for a fresh one.
   always @(posedge mclk) begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      nvm_rdata <= ~nvm_rdata;
      if (nvm_rd) begin
         nvm_rdata <= mem[nvm_addr];
      end
      if (nvm_wr) begin
         mem[nvm_addr] <= nvm_wdata;
      end
      if (adc_start) begin
         wait_q <= slow ? 9 : 1;
         sel_q <= chan_sel;
      end else if (wait_q > 0) begin
         wait_q <= wait_q - 1;
      end else if (wait_q == 0) begin
         adc_valid <= 1'b1;
         adc_data <= sel_q ? y_raw : x_raw;
         wait_q <= -1;
      end
   end
endmodule

// [verification/aom_core_test.sv]
// Self-checking bench of the angle output mapping core.
// Assumes the far-side model answers converter starts and storage reads.
`timescale 1ns/1ps
module aom_core_test;
   logic mclk = 1'b0, rst = 1'b1, adc_valid, adc_start, chan_sel, magnet_weak, bridge_open, supply_bad, slow;
   logic nvm_rd, nvm_wr, link_wr, link_rd, link_rvalid, link_refused, diag_active, boot_done, locked;
   logic [11:0] adc_data, dac_code, x_raw, y_raw, off_x, off_y;
   logic [3:0] nvm_addr, link_addr;
   logic [21:0] nvm_wdata, nvm_rdata;
   logic [15:0] link_wdata, link_rdata, rd, junk, user0;
   logic [31:0] seed = 32'h2e7e86d0;
   int err_total = 0, checked = 0, n;
   // The last row puts the zero angle exactly on the measured angle, so both zero-point checks are reached.
   logic [15:0] tz [5] = '{16'h4000, 16'h4000, 16'h4000, 16'hc000, 16'hfff9};
   logic [15:0] tm [5] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0100};
   logic [15:0] ts [5] = '{16'hffff, 16'h8000, 16'hffff, 16'h8000, 16'h8000};
   logic tu [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   initial begin
      forever begin
         #10 mclk = ~mclk;
      end
   end
   aom_core dut (.mclk(mclk), .rst(rst), .adc_data(adc_data), .adc_valid(adc_valid), .adc_start(adc_start),
      .chan_sel(chan_sel), .chan_offset_x(off_x), .chan_offset_y(off_y), .magnet_weak(magnet_weak),
      .bridge_open(bridge_open), .supply_bad(supply_bad), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .link_wr(link_wr), .link_rd(link_rd), .link_addr(link_addr),
      .link_wdata(link_wdata), .link_rdata(link_rdata), .link_rvalid(link_rvalid), .link_refused(link_refused),
      .dac_code(dac_code), .diag_active(diag_active), .boot_done(boot_done), .locked(locked));
   aom_far_side far (.mclk(mclk), .adc_start(adc_start), .chan_sel(chan_sel), .x_raw(x_raw), .y_raw(y_raw),
      .slow(slow), .adc_data(adc_data), .adc_valid(adc_valid), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
      .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_up(input int cnt, input int lim);
      if (cnt >= lim) begin
         err_total++;
         final_report();
      end
   endtask
   // Two full conversion pairs guarantee one mapping made wholly under the new settings.
   task automatic settle();
      int s = 0;
      int c = 0;
      while (s < 4 && c < 2000) begin
         @(posedge mclk);
         c++;
         if (adc_start === 1'b1) s++;
      end
      give_up(c, 2000);
      @(negedge mclk);
   endtask
   task automatic link_op(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic ref_exp,
         output logic [15:0] r);
      @(negedge mclk);
      link_wr = wr;
      link_rd = !wr;
      link_addr = a;
      link_wdata = d;
      #5 chk(16'(link_refused), 16'(ref_exp));
      @(negedge mclk);
      link_wr = 1'b0;
      link_rd = 1'b0;
      r = link_rdata;
      if (!wr && !ref_exp) chk(16'(link_rvalid), 16'h0001);
   endtask
   task automatic put(input logic [3:0] a, input logic [15:0] d);
      link_op(1'b1, a, d, 1'b0, junk);
   endtask
   task automatic boot();
      for (n = 0; n < 40 && boot_done !== 1'b1; n++) @(negedge mclk);
      give_up(n, 40);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {link_wr, link_rd, link_addr, link_wdata, magnet_weak, bridge_open, supply_bad, slow} = '0;
      x_raw = 12'hf00;
      y_raw = 12'h800;
      {off_x, off_y} = {12'h800, 12'h800};
      #1 far.mem[3] = 22'h008000; // One flipped bit that correction must hide.
      repeat (4) @(negedge mclk);
      chk(16'(dac_code), 16'(aom_pkg::DIAG_LOW_CODE));
      chk(16'(boot_done), 16'h0000);
      rst = 1'b0;
      link_op(1'b1, 4'h7, 16'h1234, 1'b1, junk);
      boot();
      settle();
      chk(16'(diag_active), 16'h0000);
      chk(16'(dac_code), 16'(aom_pkg::VALID_MIN));
      $display("test boot done");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         slow = seed[16];
         put(4'(7 + i % 2), seed[15:0]);
         link_op(1'b0, 4'(7 + i % 2), 16'h0000, 1'b0, rd);
         chk(rd, seed[15:0]);
         if (i == 4) user0 = seed[15:0];
      end
      link_op(1'b0, 4'h9, 16'h0000, 1'b1, junk);
      link_op(1'b1, 4'hf, 16'h0000, 1'b1, junk);
      $display("test user words done");
      put(4'h4, 16'h0200);
      put(4'h3, 16'h0e00);
      put(4'h5, 16'h0001);
      for (int r = 0; r < 10; r++) begin
         put(4'h0, tz[r / 2]);
         put(4'h1, tm[r / 2]);
         put(4'h2, ts[r / 2]);
         put(4'h6, 16'(r % 2));
         // Offsets move with the raw samples, so only a missing cancellation can shift the angle.
         seed = lfsr(seed);
         off_x = {2'b01, seed[9:0]};
         off_y = {2'b01, seed[25:16]};
         x_raw = off_x + 12'h700;
         y_raw = off_y;
         settle();
         chk(16'(dac_code), (tu[r / 2] ^ r[0]) ? 16'h0e00 : 16'h0200);
      end
      $display("test mapping done");
      for (int r = 0; r < 3; r++) begin
         put(4'h6, 16'h0006);
         {magnet_weak, bridge_open, supply_bad} = 3'b100 >> r;
         for (n = 0; n < 20 && diag_active !== 1'b1; n++) @(negedge mclk);
         give_up(n, 20);
         @(negedge mclk);
         chk(16'(dac_code), (r == 2) ? 16'h0020 : 16'h0fe0);
         {magnet_weak, bridge_open, supply_bad} = 3'b000;
         settle();
         chk(16'(diag_active), 16'h0000);
      end
      $display("test diagnosis done");
      put(4'h6, 16'h8000);
      chk(16'(locked), 16'h0001);
      link_op(1'b1, 4'h7, 16'hbeef, 1'b1, junk);
      link_op(1'b0, 4'h7, 16'h0000, 1'b0, rd);
      chk(rd, user0);
      $display("test lock done");
      rst = 1'b1;
      far.mem[7] = far.mem[7] ^ 22'h000028; // Two flipped bits cannot be repaired.
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      boot();
      settle();
      chk(16'(locked), 16'h0001);
      chk(16'(diag_active), 16'h0001);
      chk(16'(dac_code), 16'h0020);
      $display("test double error done");
      final_report();
   end
endmodule
